// File: core/mcbs_defs.vh
// constants for the memory card backup sequencer
`ifndef MCBS_DEFS_VH
`define MCBS_DEFS_VH

// register byte offsets
`define MCBS_ADDR_CTRL      8'h00
`define MCBS_ADDR_STAT      8'h04
`define MCBS_ADDR_ISTAT     8'h08
`define MCBS_ADDR_IMASK     8'h0c

// control register fields and reset value
`define MCBS_CTRL_V3        0
`define MCBS_CTRL_KEEPIO    1
`define MCBS_CTRL_KEEPFRC   2
`define MCBS_CTRL_W         3
`define MCBS_CTRL_RST       3'h1

// status register field positions
`define MCBS_STAT_STATE_LSB 0
`define MCBS_STAT_ITEM_LSB  4
`define MCBS_STAT_OP_LSB    8
`define MCBS_STAT_MODE_LSB  10
`define MCBS_STAT_LOCK      12
`define MCBS_STAT_RESTORED  13
`define MCBS_STAT_SKIPPED   14
`define MCBS_STAT_AUTOXFER  15
`define MCBS_STAT_BSEL      16
`define MCBS_STAT_WPROT     17

// interrupt status / mask fields and reset values
`define MCBS_INT_DONE       0
`define MCBS_INT_ERR        1
`define MCBS_INT_MISM       2
`define MCBS_INT_REFUSE     3
`define MCBS_INT_W          4
`define MCBS_ISTAT_RST      4'h0
`define MCBS_IMASK_RST      4'h0

// card operations
`define MCBS_OP_NONE        2'h0
`define MCBS_OP_BACKUP      2'h1
`define MCBS_OP_RESTORE     2'h2
`define MCBS_OP_COMPARE     2'h3

// backup items, in transfer order
`define MCBS_ITEM_PROG      3'h0
`define MCBS_ITEM_PARAM     3'h1
`define MCBS_ITEM_IOM       3'h2
`define MCBS_ITEM_SYM       3'h3
`define MCBS_ITEM_CMT       3'h4
`define MCBS_ITEM_IDX       3'h5
`define MCBS_ITEM_LAST_OLD  3'h2
`define MCBS_ITEM_LAST_V3   3'h5

// operating modes
`define MCBS_MODE_PROG      2'h0
`define MCBS_MODE_MON       2'h1
`define MCBS_MODE_RUN       2'h2

// timing
`define MCBS_HOLD_MS        3000
`define MCBS_CLK_MHZ        100
`define MCBS_HOLD_CYCLES    (`MCBS_HOLD_MS * 1000 * `MCBS_CLK_MHZ)
`define MCBS_SETTLE_CYC     3'h4

`endif

// File: core/mcbs_sync.v
// two-flop synchroniser for asynchronous pin levels
`default_nettype none
module mcbs_sync #(
  parameter W = 1
) (
  input  wire         clk_i,
  input  wire         srst_i,
  input  wire         en_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
    end else if (en_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end

  assign q_o = s2_q;
endmodule
`default_nettype wire

// File: core/mcbs_hold_timer.v
// button hold timer: one pulse per continuous press held long enough
`default_nettype none
module mcbs_hold_timer #(
  parameter        CNT_W       = 32,
  parameter [31:0] HOLD_CYCLES = 32'd300000000
) (
  input  wire clk_i,
  input  wire srst_i,
  input  wire en_i,
  input  wire press_i,
  output reg  fire_o
);
  reg [CNT_W-1:0] cnt_q;
  reg             fired_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q   <= {CNT_W{1'b0}};
      fired_q <= 1'b0;
      fire_o  <= 1'b0;
    end else if (en_i) begin
      fire_o <= 1'b0;
      if (!press_i) begin
        cnt_q   <= {CNT_W{1'b0}};
        fired_q <= 1'b0;
      end else if (!fired_q) begin
        if (cnt_q == HOLD_CYCLES[CNT_W-1:0] - 1'b1) begin
          fire_o  <= 1'b1;
          fired_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: core/mcbs_top.v
// memory card backup sequencer: backup, power-up restore and compare
`include "mcbs_defs.vh"
`default_nettype none
module mcbs_top #(
  parameter        CNT_W       = 32,
  parameter [31:0] HOLD_CYCLES = `MCBS_HOLD_CYCLES
) (
  input  wire        mclk_i,
  input  wire        srst_i,
  input  wire        en_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output wire        pready_o,
  output wire        pslverr_o,
  output wire        irq_o,
  input  wire        backup_sel_pin_i,
  input  wire        auto_xfer_pin_i,
  input  wire        wprot_pin_i,
  input  wire        card_btn_pin_i,
  input  wire        io_memory_hold_bit_i,
  input  wire        forced_status_hold_bit_i,
  output wire        card_req_o,
  output reg  [1:0]  card_op_o,
  output reg  [2:0]  card_item_o,
  output reg  [1:0]  card_wflags_o,
  input  wire        card_ack_i,
  input  wire        card_err_i,
  input  wire [1:0]  card_rflags_i,
  output reg         clear_io_o,
  output reg         clear_force_o,
  output reg         autoxfer_start_o,
  output reg         startup_done_o,
  input  wire        mode_req_valid_i,
  input  wire [1:0]  mode_req_i,
  output reg  [1:0]  mode_o,
  output reg         mode_lock_o
);
  localparam [2:0] S_BOOT = 3'h0;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_REQ  = 3'h2;
  localparam [2:0] S_FIN  = 3'h3;

  // synchronised switch pins
  wire [3:0] pins_s;
  wire       bsel_s;
  wire       auto_s;
  wire       wprot_s;
  wire       btn_s;
  wire       fire;

  mcbs_sync #(
    .W (4)
  ) u_sync (
    .clk_i  (mclk_i),
    .srst_i (srst_i),
    .en_i   (en_i),
    .d_i    ({card_btn_pin_i, wprot_pin_i, auto_xfer_pin_i, backup_sel_pin_i}),
    .q_o    (pins_s)
  );

  assign bsel_s  = pins_s[0];
  assign auto_s  = pins_s[1];
  assign wprot_s = pins_s[2];
  assign btn_s   = pins_s[3];

  // the timer sees the synchronised button only
  mcbs_hold_timer #(
    .CNT_W       (CNT_W),
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .clk_i   (mclk_i),
    .srst_i  (srst_i),
    .en_i    (en_i),
    .press_i (btn_s),
    .fire_o  (fire)
  );

  reg [2:0]             state_q;
  reg [2:0]             boot_cnt_q;
  reg                   fin_err_q;
  reg [1:0]             rflags_q;
  reg                   restored_q;
  reg                   skipped_q;
  reg                   autoxfer_q;
  reg [`MCBS_CTRL_W-1:0] ctrl_q;
  reg [`MCBS_INT_W-1:0] istat_q;
  reg [`MCBS_INT_W-1:0] imask_q;
  reg [`MCBS_INT_W-1:0] ev;
  reg [`MCBS_INT_W-1:0] w1c;
  reg [31:0]            rd;
  reg                   mapped;
  wire                  wr_acc;
  wire                  wr_ctrl;
  wire                  wr_istat;
  wire                  wr_imask;
  wire                  rd_setup;
  wire [2:0]            last_item;
  wire                  mode_refuse;

  // last item of the sequence depends on unit version
  assign last_item = ctrl_q[`MCBS_CTRL_V3] ? `MCBS_ITEM_LAST_V3 : `MCBS_ITEM_LAST_OLD;

  function is_mapped;
    input [7:0] a;
    begin
      is_mapped = (a == `MCBS_ADDR_CTRL) || (a == `MCBS_ADDR_STAT) ||
                  (a == `MCBS_ADDR_ISTAT) || (a == `MCBS_ADDR_IMASK);
    end
  endfunction

  // write strobe for one register in the access phase
  function wr_hit;
    input       acc;
    input [7:0] a;
    input [7:0] reg_a;
    begin
      wr_hit = acc && (a == reg_a);
    end
  endfunction

  // apb slave: zero wait states, stalled while the clock enable is low
  assign pready_o  = en_i;
  assign pslverr_o = psel_i & penable_i & ~is_mapped(paddr_i);
  assign wr_acc    = en_i & psel_i & penable_i & pwrite_i;
  assign rd_setup  = en_i & psel_i & ~penable_i & ~pwrite_i;
  assign wr_ctrl   = wr_hit(wr_acc, paddr_i, `MCBS_ADDR_CTRL);
  assign wr_istat  = wr_hit(wr_acc, paddr_i, `MCBS_ADDR_ISTAT);
  assign wr_imask  = wr_hit(wr_acc, paddr_i, `MCBS_ADDR_IMASK);

  always @* begin
    rd     = 32'h00000000;
    mapped = is_mapped(paddr_i);
    case (paddr_i)
      `MCBS_ADDR_CTRL: begin
        rd[`MCBS_CTRL_W-1:0] = ctrl_q;
      end
      `MCBS_ADDR_STAT: begin
        rd[`MCBS_STAT_STATE_LSB +: 3] = state_q;
        rd[`MCBS_STAT_ITEM_LSB +: 3]  = card_item_o;
        rd[`MCBS_STAT_OP_LSB +: 2]    = card_op_o;
        rd[`MCBS_STAT_MODE_LSB +: 2]  = mode_o;
        rd[`MCBS_STAT_LOCK]           = mode_lock_o;
        rd[`MCBS_STAT_RESTORED]       = restored_q;
        rd[`MCBS_STAT_SKIPPED]        = skipped_q;
        rd[`MCBS_STAT_AUTOXFER]       = autoxfer_q;
        rd[`MCBS_STAT_BSEL]           = bsel_s;
        rd[`MCBS_STAT_WPROT]          = wprot_s;
      end
      `MCBS_ADDR_ISTAT: begin
        rd[`MCBS_INT_W-1:0] = istat_q;
      end
      `MCBS_ADDR_IMASK: begin
        rd[`MCBS_INT_W-1:0] = imask_q;
      end
      default: begin
        rd = 32'h00000000;
      end
    endcase
  end

  // read data is captured in setup and stands through the access phase
  always @(posedge mclk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h00000000;
      ctrl_q   <= `MCBS_CTRL_RST;
      imask_q  <= `MCBS_IMASK_RST;
    end else if (en_i) begin
      if (rd_setup) begin
        prdata_o <= mapped ? rd : 32'h00000000;
      end
      if (wr_ctrl) begin
        ctrl_q <= pwdata_i[`MCBS_CTRL_W-1:0];
      end
      if (wr_imask) begin
        imask_q <= pwdata_i[`MCBS_INT_W-1:0];
      end
    end
  end

  // mode requests: only program mode is accepted while locked
  assign mode_refuse = mode_req_valid_i &&
                       ((mode_lock_o && mode_req_i != `MCBS_MODE_PROG) ||
                        mode_req_i == 2'h3);

  // event pulses feeding the sticky status
  always @* begin
    ev = {`MCBS_INT_W{1'b0}};
    w1c = {`MCBS_INT_W{1'b0}};
    if (wr_istat) begin
      w1c = pwdata_i[`MCBS_INT_W-1:0];
    end
    if (state_q == S_FIN) begin
      ev[`MCBS_INT_DONE] = 1'b1;
    end
    // compare mismatches report apart from transfer errors
    if (state_q == S_REQ && card_ack_i && card_err_i) begin
      if (card_op_o == `MCBS_OP_COMPARE) begin
        ev[`MCBS_INT_MISM] = 1'b1;
      end else begin
        ev[`MCBS_INT_ERR] = 1'b1;
      end
    end
    ev[`MCBS_INT_REFUSE] = mode_refuse;
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      istat_q <= `MCBS_ISTAT_RST;
    end else if (en_i) begin
      // a new event wins over a simultaneous clear
      istat_q <= (istat_q & ~w1c) | ev;
    end
  end

  // level interrupt from any unmasked sticky bit
  assign irq_o = |(istat_q & imask_q);

  // request stands for as long as the sequencer waits on the card
  assign card_req_o = (state_q == S_REQ);

  // sequencer
  always @(posedge mclk_i) begin
    if (srst_i) begin
      state_q          <= S_BOOT;
      boot_cnt_q       <= 3'h0;
      fin_err_q        <= 1'b0;
      rflags_q         <= 2'h0;
      restored_q       <= 1'b0;
      skipped_q        <= 1'b0;
      autoxfer_q       <= 1'b0;
      card_op_o        <= `MCBS_OP_NONE;
      card_item_o      <= `MCBS_ITEM_PROG;
      card_wflags_o    <= 2'h0;
      clear_io_o       <= 1'b0;
      clear_force_o    <= 1'b0;
      autoxfer_start_o <= 1'b0;
      startup_done_o   <= 1'b0;
      mode_o           <= `MCBS_MODE_PROG;
      mode_lock_o      <= 1'b0;
    end else if (en_i) begin
      clear_io_o       <= 1'b0;
      clear_force_o    <= 1'b0;
      autoxfer_start_o <= 1'b0;
      if (mode_req_valid_i && !mode_refuse) begin
        mode_o <= mode_req_i;
      end
      case (state_q)
        S_BOOT: begin
          // wait for the synchronised switches to settle after power-up
          if (boot_cnt_q != `MCBS_SETTLE_CYC) begin
            boot_cnt_q <= boot_cnt_q + 1'b1;
          end else if (bsel_s) begin
            // protected program memory: no card access, no auto-transfer
            if (wprot_s) begin
              skipped_q      <= 1'b1;
              startup_done_o <= 1'b1;
              state_q        <= S_IDLE;
            end else begin
              card_op_o   <= `MCBS_OP_RESTORE;
              card_item_o <= `MCBS_ITEM_PROG;
              state_q     <= S_REQ;
            end
          end else begin
            autoxfer_start_o <= auto_s;
            autoxfer_q       <= auto_s;
            startup_done_o   <= 1'b1;
            state_q          <= S_IDLE;
          end
        end
        S_IDLE: begin
          if (fire) begin
            // no mode check: backup and compare run in any mode
            card_op_o     <= bsel_s ? `MCBS_OP_BACKUP : `MCBS_OP_COMPARE;
            card_item_o   <= `MCBS_ITEM_PROG;
            card_wflags_o <= {forced_status_hold_bit_i & ctrl_q[`MCBS_CTRL_KEEPFRC],
                              io_memory_hold_bit_i & ctrl_q[`MCBS_CTRL_KEEPIO]};
            state_q       <= S_REQ;
          end
        end
        S_REQ: begin
          // waits for the card without any time limit
          if (card_ack_i) begin
            // keep flags ride with the io memory item of a restore
            if (card_op_o == `MCBS_OP_RESTORE && card_item_o == `MCBS_ITEM_IOM) begin
              rflags_q <= card_rflags_i;
            end
            if (card_err_i) begin
              fin_err_q <= 1'b1;
              state_q   <= S_FIN;
            end else if (card_item_o == last_item) begin
              fin_err_q <= 1'b0;
              state_q   <= S_FIN;
            end else begin
              card_item_o <= card_item_o + 3'h1;
            end
          end
        end
        S_FIN: begin
          // the lock only falls with a power-on reset
          if (card_op_o == `MCBS_OP_BACKUP) begin
            mode_lock_o <= 1'b1;
            mode_o      <= `MCBS_MODE_PROG;
          end
          if (card_op_o == `MCBS_OP_RESTORE) begin
            startup_done_o <= 1'b1;
            if (!fin_err_q) begin
              restored_q    <= 1'b1;
              clear_io_o    <= ~rflags_q[0];
              clear_force_o <= ~rflags_q[1];
            end
          end
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: core/_unused_placeholder_none.v
// intentionally empty design unit list terminator
`default_nettype none
`default_nettype wire

// File: test/mcbs_sva.sv
// concurrent checks on the backup sequencer ports
`include "mcbs_defs.vh"
`default_nettype none
module mcbs_sva #(
  parameter [31:0] HOLD_CYCLES = 32'd20
) (
  input wire logic       mclk_i,
  input wire logic       srst_i,
  input wire logic       backup_sel_pin_i,
  input wire logic       wprot_pin_i,
  input wire logic       card_btn_pin_i,
  input wire logic       card_req_o,
  input wire logic [1:0] card_op_o,
  input wire logic [2:0] card_item_o,
  input wire logic       card_ack_i,
  input wire logic       card_err_i,
  input wire logic       autoxfer_start_o,
  input wire logic [1:0] mode_o,
  input wire logic       mode_lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] held_q;
  logic        used_q;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // cycles the button pin has been high without a break
  always @(posedge mclk_i) begin
    if (!card_btn_pin_i)
      held_q <= 32'h0;
    else if (held_q != 32'hffffffff)
      held_q <= held_q + 32'h1;
  end
  // press already spent on an operation
  always @(posedge mclk_i) begin
    if (srst_i || !card_btn_pin_i)
      used_q <= 1'b0;
    else if (card_req_o)
      used_q <= 1'b1;
  end
  property p_stand;
    card_req_o && !card_ack_i |=> card_req_o && $stable(card_op_o) && $stable(card_item_o);
  endproperty
  a_stand: assert property (p_stand) else $error("card request not held");
  property p_next;
    card_req_o && card_ack_i && !card_err_i |=>
      !card_req_o || card_item_o == $past(card_item_o) + 3'h1;
  endproperty
  a_next: assert property (p_next) else $error("item order broken");
  property p_abort;
    card_req_o && card_ack_i && card_err_i |=> !card_req_o;
  endproperty
  a_abort: assert property (p_abort) else $error("error did not stop");
  property p_wprot;
    card_req_o && card_op_o == `MCBS_OP_RESTORE |-> !wprot_pin_i;
  endproperty
  a_wprot: assert property (p_wprot) else $error("restore under protect");
  property p_autox;
    autoxfer_start_o |-> !backup_sel_pin_i;
  endproperty
  a_autox: assert property (p_autox) else $error("auto transfer over restore");
  property p_lock;
    mode_lock_o && $past(mode_lock_o) |-> mode_o == `MCBS_MODE_PROG;
  endproperty
  a_lock: assert property (p_lock) else $error("locked but not program mode");
  property p_hold;
    $rose(card_req_o) && card_btn_pin_i |-> held_q >= HOLD_CYCLES;
  endproperty
  a_hold: assert property (p_hold) else $error("operation before full hold");
  property p_once;
    $rose(card_req_o) |-> !used_q;
  endproperty
  a_once: assert property (p_once) else $error("second operation in one press");
  c_bk: cover property (card_req_o && card_op_o == `MCBS_OP_BACKUP);
  c_rs: cover property (card_req_o && card_op_o == `MCBS_OP_RESTORE);
  c_cp: cover property (card_req_o && card_op_o == `MCBS_OP_COMPARE);
endmodule
bind mcbs_top mcbs_sva #(.HOLD_CYCLES(HOLD_CYCLES)) mcbs_sva_inst (.mclk_i, .srst_i,
  .backup_sel_pin_i, .wprot_pin_i, .card_btn_pin_i, .card_req_o, .card_op_o, .card_item_o,
  .card_ack_i, .card_err_i, .autoxfer_start_o, .mode_o, .mode_lock_o);
`default_nettype wire

// File: test/mcbs_card_model.sv
// memory card model: answers item transfers, stores keep flags
`default_nettype none
module mcbs_card_model (
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  input  wire logic       req_i,
  input  wire logic [1:0] op_i,
  input  wire logic [2:0] item_i,
  input  wire logic [1:0] wflags_i,
  input  wire logic [7:0] dly_i,
  input  wire logic       bad_i,
  output var  logic       ack_o,
  output var  logic       err_o,
  output wire logic [1:0] rflags_o,
  output var  logic [7:0] seen_o,
  output var  logic [1:0] op_o,
  output var  logic [1:0] store_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  // flags only valid with the ack, inverted otherwise
  assign rflags_o = ack_o ? store_o : ~store_o;
  initial begin
    {ack_o, err_o, seen_o, op_o, store_o, cnt} = '0;
  end
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    if (clr_i) begin
      seen_o <= 8'h0;
      cnt <= 8'h0;
    end else if (req_i && !ack_o) begin
      cnt <= cnt + 8'h1;
      if (cnt >= dly_i) begin
        cnt <= 8'h0;
        ack_o <= 1'b1;
        err_o <= bad_i && item_i == 3'h1;
        seen_o[item_i] <= 1'b1;
        op_o <= op_i;
        if (op_i == 2'h1 && item_i == 3'h2)
          store_o <= wflags_i;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/tb.sv
// self-checking bench for the backup sequencer
`include "mcbs_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic s; logic v3; logic [1:0] m; logic [1:0] op; logic [7:0] sn;} mcbs_row_t;
  mcbs_row_t rows [4] = '{'{1'b1, 1'b1, 2'h2, 2'h1, 8'h3f}, '{1'b1, 1'b0, 2'h1, 2'h1, 8'h07},
                        '{1'b0, 1'b1, 2'h2, 2'h3, 8'h3f}, '{1'b0, 1'b0, 2'h0, 2'h3, 8'h07}};
  logic [3:0] ft [3] = '{4'hf, 4'hb, 4'hc};
  logic mclk_i = 0, srst_i = 1, psel = 0, pen = 0, pwr = 0, sel = 0, ax = 0, wp = 0;
  logic btn = 0, ioh = 0, fsh = 0, mv = 0, clr = 1, bad = 0, er;
  logic [7:0] pa = 0, dly = 8'h2, seen;
  logic [31:0] pwd = 0, rd, prd;
  logic [2:0] item;
  logic [1:0] mq = 0, op, wfl, rfl, mode, mop, mst;
  logic prdy, perr, irq, req, ack, err, cio, cfo, axo, sdone, lock, cio_s, cfo_s, ax_s;
  int err_total = 0, check_count = 0, nops = 0;
  mcbs_top #(.HOLD_CYCLES(32'd20)) mcbs_top_inst (.mclk_i(mclk_i), .srst_i(srst_i),
    .en_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .irq_o(irq),
    .backup_sel_pin_i(sel), .auto_xfer_pin_i(ax), .wprot_pin_i(wp), .card_btn_pin_i(btn),
    .io_memory_hold_bit_i(ioh), .forced_status_hold_bit_i(fsh), .card_req_o(req),
    .card_op_o(op), .card_item_o(item), .card_wflags_o(wfl), .card_ack_i(ack),
    .card_err_i(err), .card_rflags_i(rfl), .clear_io_o(cio), .clear_force_o(cfo),
    .autoxfer_start_o(axo), .startup_done_o(sdone), .mode_req_valid_i(mv),
    .mode_req_i(mq), .mode_o(mode), .mode_lock_o(lock));
  mcbs_card_model mcbs_card_model_inst (.clk_i(mclk_i), .clr_i(clr), .req_i(req),
    .op_i(op), .item_i(item), .wflags_i(wfl), .dly_i(dly), .bad_i(bad), .ack_o(ack),
    .err_o(err), .rflags_o(rfl), .seen_o(seen), .op_o(mop), .store_o(mst));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // sticky records of one-cycle pulses, and a count of acks on the first item
  always @(posedge mclk_i) begin
    cio_s <= !clr && (cio_s || cio);
    cfo_s <= !clr && (cfo_s || cfo);
    ax_s <= !clr && (ax_s || axo);
    nops <= clr ? 0 : nops + int'(ack && item == 3'h0);
  end
  task automatic summarize();
    $display("counts checks=%0d bad=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge mclk_i);
    pen <= 1;
    do @(posedge mclk_i); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 0;
    pen <= 0;
  endtask
  task automatic boot(input logic s, input logic w, input logic a);
    @(posedge mclk_i);
    srst_i <= 1;
    clr <= 1;
    sel <= s;
    wp <= w;
    ax <= a;
    btn <= 0;
    cyc(10);
    srst_i <= 0;
    clr <= 0;
    for (int i = 0; i < 3000 && sdone !== 1'b1; i++) @(posedge mclk_i);
    cyc(3);
    chk(sdone, 1);
  endtask
  task automatic press();
    btn <= 1;
    for (int i = 0; i < 200 && req !== 1'b1; i++) @(posedge mclk_i);
    for (int i = 0; i < 2000 && req !== 1'b0; i++) @(posedge mclk_i);
    cyc(3);
    btn <= 0;
    cyc(4);
  endtask
  initial begin
    cyc(20000);
    err_total++;
    summarize();
  end
  initial begin
    boot(0, 0, 1);
    chk(ax_s, 1);
    chk(seen, 0);
    apb(0, `MCBS_ADDR_CTRL, 0);
    chk(rd, `MCBS_CTRL_RST);
    apb(0, `MCBS_ADDR_IMASK, 0);
    chk(rd, `MCBS_IMASK_RST);
    apb(0, 8'h10, 0);
    chk({er, rd[30:0]}, 32'h80000000);
    $display("test reset done");
    foreach (rows[k]) begin
      boot(0, 0, 0);
      apb(1, `MCBS_ADDR_CTRL, {31'h0, rows[k].v3});
      mq <= rows[k].m;
      mv <= 1;
      cyc(1);
      mv <= 0;
      sel <= rows[k].s;
      cyc(4);
      press();
      chk(mop, rows[k].op);
      chk(seen, rows[k].sn);
      chk(mode, rows[k].s ? 2'h0 : rows[k].m);
      chk(lock, rows[k].s);
      $display("test row %0d done", k);
    end
    for (int j = 0; j < 3; j++) begin
      boot(0, 0, 0);
      apb(1, `MCBS_ADDR_CTRL, {29'h0, ft[j][1:0], 1'b1});
      ioh <= ft[j][3];
      fsh <= ft[j][2];
      sel <= 1;
      cyc(4);
      press();
      chk(mst, {ft[j][2] & ft[j][1], ft[j][3] & ft[j][0]});
      boot(1, 0, 1);
      chk(lock, 0);
      chk(mop, `MCBS_OP_RESTORE);
      chk(seen, 8'h3f);
      chk(ax_s, 0);
      chk(cio_s, !(ft[j][3] & ft[j][0]));
      chk(cfo_s, !(ft[j][2] & ft[j][1]));
    end
    $display("test restore done");
    apb(1, `MCBS_ADDR_IMASK, 32'h8);
    sel <= 0;
    mq <= 2'h2;
    mv <= 1;
    cyc(1);
    mv <= 0;
    cyc(3);
    chk(mode, 2'h2);
    boot(1, 0, 0);
    chk(cio_s, 1);
    chk(cfo_s, 1);
    sel <= 1;
    cyc(4);
    press();
    apb(1, `MCBS_ADDR_IMASK, 32'h8);
    mv <= 1;
    cyc(1);
    mv <= 0;
    cyc(3);
    chk(mode, 0);
    chk(irq, 1);
    apb(1, `MCBS_ADDR_ISTAT, 32'h8);
    cyc(1);
    chk(irq, 0);
    mq <= 2'h3;
    mv <= 1;
    cyc(1);
    mv <= 0;
    cyc(3);
    chk(irq, 1);
    chk(mode, 0);
    $display("test lock done");
    boot(1, 1, 1);
    chk(seen, 0);
    apb(0, `MCBS_ADDR_STAT, 0);
    chk(rd[17:12], 6'h34);
    boot(0, 0, 0);
    btn <= 1;
    cyc(15);
    btn <= 0;
    cyc(5);
    btn <= 1;
    cyc(15);
    btn <= 0;
    cyc(5);
    chk(nops, 0);
    dly <= 8'h3c;
    bad <= 1;
    btn <= 1;
    cyc(400);
    btn <= 0;
    cyc(4);
    chk(nops, 1);
    chk(seen, 8'h03);
    apb(0, `MCBS_ADDR_ISTAT, 0);
    chk(rd[2], 1);
    $display("test press done");
    summarize();
  end
endmodule
`default_nettype wire
